/* pmwc_cpu_model.sv */
// cpu core stand-in: takes interrupt vectors and returns from service
`timescale 1ns/1ps

module pmwc_cpu_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // interrupt handshake
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        cc_push,
  input  wire logic        hold_ret,
  output logic             vec_ack = 1'b0,
  output logic             iret_pop = 1'b0,
  // observation for the bench
  output logic             ack_stb = 1'b0,
  output logic [15:0]      ack_vec = 16'h0000
);
  int unsigned dly_q;
  int unsigned ret_q;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      vec_ack  <= 1'b0;
      ack_stb  <= 1'b0;
      iret_pop <= 1'b0;
      dly_q    <= 0;
      ret_q    <= 0;
    end else begin
      ack_stb  <= vec_ack && irq_req;
      iret_pop <= !cc_push && ret_q == 1 && !hold_ret;
      if (vec_ack) begin
        vec_ack <= 1'b0;
        if (irq_req) begin
          ack_vec <= irq_vector;
        end
      end else if (irq_req && dly_q == 0) begin
        vec_ack <= 1'b1;
        // prompt or slow answer, so request must stand while waiting
        dly_q   <= $urandom_range(2);
      end else if (irq_req) begin
        dly_q <= dly_q - 1;
      end
      if (cc_push) begin
        ret_q <= 8;
      end else if (ret_q != 0 && !hold_ret) begin
        ret_q <= ret_q - 1;
      end
    end
  end
endmodule

/* pmwc_defines.svh */
// offsets, field positions, reset values, vectors and timing counts
`ifndef PMWC_DEFINES_SVH
`define PMWC_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PMWC_OFS_MISC 4'h0
`define PMWC_OFS_CRSS 4'h4
`define PMWC_OFS_STAT 4'h8

// ****************************************
// field positions
// ****************************************
`define PMWC_MISC_SEL_LO 0
`define PMWC_MISC_SEL_HI 1
`define PMWC_MISC_SMS    2
`define PMWC_CRSS_FLAG   1
`define PMWC_CRSS_IE     2

// ****************************************
// reset values and divide ratios
// ****************************************
`define PMWC_RST_SMS     1'b0
`define PMWC_RST_SEL     2'h0
`define PMWC_RST_IE      1'b0
`define PMWC_DIV_RUN     6'h02
`define PMWC_DIV_SLOW    6'h04

// ****************************************
// vector addresses (first byte)
// ****************************************
`define PMWC_VEC_TRAP    16'hFFFC
`define PMWC_VEC_EXTA    16'hFFFA
`define PMWC_VEC_EXTB    16'hFFF8
`define PMWC_VEC_CSS     16'hFFF6
`define PMWC_VEC_SPI     16'hFFF4
`define PMWC_VEC_TIM1    16'hFFF2
`define PMWC_VEC_TIM2    16'hFFEE
`define PMWC_VEC_I2C     16'hFFE4

// ****************************************
// halt exit stabilisation, in cpu cycles
// ****************************************
`define PMWC_STARTUP_CYC  4096
`define PMWC_STARTUP_LAST 12'((`PMWC_STARTUP_CYC) - 1)

`endif

/* pmwc_pkg.sv */
// types shared by the power mode and wake controller
package pmwc_pkg;

  typedef enum logic [3:0] {
    PMWC_S_RUN   = 4'h1,
    PMWC_S_WAIT  = 4'h2,
    PMWC_S_HALT  = 4'h4,
    PMWC_S_START = 4'h8
  } pmwc_state_t;

  // source slots, index order is service priority
  typedef logic [2:0] pmwc_src_t;

endpackage

/* pmwc_top.sv */
// power mode, clock divide and interrupt wake controller
`timescale 1ns/1ps
`include "pmwc_defines.svh"

module pmwc_top
  import pmwc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // cpu core
  input  wire logic        wait_for_interrupt_instr,
  input  wire logic        halt_instr,
  input  wire logic        trap_instr,
  input  wire logic        iret_pop,
  input  wire logic        vec_ack,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic             i_mask,
  output logic             cc_push,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_enable,
  output logic             wdg_reset_req,
  // interrupt sources
  input  wire logic        ext_irq_group_a,
  input  wire logic        ext_irq_group_b,
  input  wire logic        clock_supervision,
  input  wire logic        spi_irq,
  input  wire logic        timer_one_status,
  input  wire logic        timer_two_status,
  input  wire logic        i2c_irq,
  // options
  input  wire logic        watchdog_en,
  input  wire logic        watchdog_in_halt_option
);

  // ****************************************
  // functions
  // ****************************************
  function automatic pmwc_src_t pick(
    input logic [7:0] v
  );
    pmwc_src_t r;
    r = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_of(
    input pmwc_src_t s
  );
    case (s)
      3'h0:    return `PMWC_VEC_TRAP;
      3'h1:    return `PMWC_VEC_EXTA;
      3'h2:    return `PMWC_VEC_EXTB;
      3'h3:    return `PMWC_VEC_CSS;
      3'h4:    return `PMWC_VEC_SPI;
      3'h5:    return `PMWC_VEC_TIM1;
      3'h6:    return `PMWC_VEC_TIM2;
      default: return `PMWC_VEC_I2C;
    endcase
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [1:0]  ext_s1_q;
  logic [1:0]  ext_s2_q;
  logic [1:0]  ext_s3_q;
  logic [1:0]  ext_rise;
  pmwc_state_t st_q, st_d;
  logic [11:0] st_cnt_q, st_cnt_d;
  logic [5:0]  div_cnt_q, div_cnt_d;
  logic [5:0]  ratio_q, ratio_d;
  logic [5:0]  ratio_new;
  logic        tick;
  logic        slow_en_q, slow_en_d;
  logic [1:0]  sel_q, sel_d;
  logic        css_ie_q, css_ie_d;
  logic        css_flag_q, css_flag_d;
  logic        ea_q, ea_d;
  logic        eb_q, eb_d;
  logic        trap_q, trap_d;
  logic        i_q, i_d;
  pmwc_src_t   src_q, src_d;
  logic [7:0]  pend;
  logic [7:0]  allow;
  logic        ack;
  logic        halt_wake;
  logic        wdg_d;
  logic        irq_d;
  logic        wreq_d;
  logic [31:0] rdata_d;
  logic        acc_wr;
  logic        rd_crss;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ext_pin;
  assign ext_pin = {ext_irq_group_b, ext_irq_group_a};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        ext_s1_q[g] <= 1'b0;
        ext_s2_q[g] <= 1'b0;
        ext_s3_q[g] <= 1'b0;
      end else begin
        ext_s1_q[g] <= ext_pin[g];
        ext_s2_q[g] <= ext_s1_q[g];
        ext_s3_q[g] <= ext_s2_q[g];
      end
    end
    assign ext_rise[g] = ext_s2_q[g] & ~ext_s3_q[g];
  end

  // ****************************************
  // clock divider
  // ****************************************
  always_comb begin
    ratio_new = `PMWC_DIV_RUN;
    if (slow_en_q) begin
      ratio_new = `PMWC_DIV_SLOW << sel_q;
    end
    div_cnt_d = div_cnt_q;
    ratio_d   = ratio_q;
    tick      = 1'b0;
    if (st_q != PMWC_S_HALT) begin
      if (div_cnt_q >= ratio_q - 6'h01) begin
        div_cnt_d = 6'h00;
        tick      = 1'b1;
        // new ratio only at period end
        ratio_d   = ratio_new;
      end else begin
        div_cnt_d = div_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      div_cnt_q <= 6'h00;
      // run mode at divide by two
      ratio_q   <= `PMWC_DIV_RUN;
    end else begin
      div_cnt_q <= div_cnt_d;
      ratio_q   <= ratio_d;
    end
  end

  // ****************************************
  // mode state machine
  // ****************************************
  // only external groups and supervision
  assign halt_wake = ea_q | eb_q | (css_flag_q & css_ie_q);

  always_comb begin
    st_d     = st_q;
    st_cnt_d = st_cnt_q;
    wdg_d    = 1'b0;
    case (st_q)
      PMWC_S_RUN: begin
        if (halt_instr) begin
          if (watchdog_en && !watchdog_in_halt_option) begin
            wdg_d = 1'b1;
          end else begin
            st_d = PMWC_S_HALT;
          end
        end else if (wait_for_interrupt_instr) begin
          st_d = PMWC_S_WAIT;
        end
      end
      PMWC_S_WAIT: begin
        if (|pend) begin
          st_d = PMWC_S_RUN;
        end
      end
      PMWC_S_HALT: begin
        // second timer is not a halt_wake term
        if (halt_wake) begin
          st_d     = PMWC_S_START;
          st_cnt_d = 12'h000;
        end
      end
      PMWC_S_START: begin
        if (tick) begin
          if (st_cnt_q == `PMWC_STARTUP_LAST) begin
            st_d = PMWC_S_RUN;
          end else begin
            st_cnt_d = st_cnt_q + 12'h001;
          end
        end
      end
      default: begin
        st_d = PMWC_S_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q          <= PMWC_S_RUN;
      st_cnt_q      <= 12'h000;
      wdg_reset_req <= 1'b0;
      osc_enable    <= 1'b1;
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      st_q          <= st_d;
      st_cnt_q      <= st_cnt_d;
      wdg_reset_req <= wdg_d;
      osc_enable    <= (st_d != PMWC_S_HALT);
      // one tick drives cpu and peripherals
      // next state gates the tick, so no cpu pulse leaks into wait
      cpu_clk_en    <= tick & (st_d == PMWC_S_RUN);
      // peripherals keep the tick in wait
      periph_clk_en <= tick & (st_d == PMWC_S_RUN ||
                               st_d == PMWC_S_WAIT);
    end
  end

  // ****************************************
  // interrupt pending, priority and mask
  // ****************************************
  // supervision gated by its enable
  assign pend = {i2c_irq, timer_two_status,
                 timer_one_status, spi_irq,
                 css_flag_q & css_ie_q,
                 eb_q, ea_q, trap_q};
  assign allow = pend & {{7{~i_q}}, 1'b1};
  assign ack   = vec_ack & irq_req;

  always_comb begin
    // port A edge latch, set wins
    ea_d   = (ea_q & ~(ack && src_q == 3'h1)) | ext_rise[0];
    // port B edge latch, set wins
    eb_d   = (eb_q & ~(ack && src_q == 3'h2)) | ext_rise[1];
    trap_d = (trap_q & ~(ack && src_q == 3'h0)) | trap_instr;
    i_d    = i_q;
    // mask set on service, cleared on pop
    if (ack) begin
      i_d = 1'b1;
    end else if (iret_pop) begin
      i_d = 1'b0;
    end
    if (st_d == PMWC_S_WAIT || st_d == PMWC_S_HALT) begin
      i_d = 1'b0;
    end
    src_d = pick(allow);
    // request only once back in run
    irq_d = (st_d == PMWC_S_RUN) & (|allow) & ~ack;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ea_q       <= 1'b0;
      eb_q       <= 1'b0;
      trap_q     <= 1'b0;
      i_q        <= 1'b1;
      src_q      <= 3'h0;
      irq_req    <= 1'b0;
      irq_vector <= `PMWC_VEC_TRAP;
      i_mask     <= 1'b1;
      cc_push    <= 1'b0;
    end else begin
      ea_q       <= ea_d;
      eb_q       <= eb_d;
      trap_q     <= trap_d;
      i_q        <= i_d;
      src_q      <= src_d;
      irq_req    <= irq_d;
      irq_vector <= vec_of(src_d);
      i_mask     <= i_d;
      cc_push    <= ack;
    end
  end

  // ****************************************
  // avalon register slave
  // ****************************************
  // one wait state per access keeps read data registered
  assign acc_wr  = avs_write & ~avs_waitrequest;
  assign rd_crss = avs_read & ~avs_waitrequest &
                   (avs_address == `PMWC_OFS_CRSS);

  always_comb begin
    wreq_d     = ~((avs_read | avs_write) & avs_waitrequest);
    rdata_d    = avs_readdata;
    slow_en_d  = slow_en_q;
    sel_d      = sel_q;
    css_ie_d   = css_ie_q;
    // read clears flag, a live event wins
    css_flag_d = clock_supervision | (css_flag_q & ~rd_crss);
    if (avs_read && avs_waitrequest) begin
      rdata_d = 32'h0000_0000;
      case (avs_address)
        `PMWC_OFS_MISC: begin
          rdata_d[`PMWC_MISC_SMS]    = slow_en_q;
          rdata_d[`PMWC_MISC_SEL_HI] = sel_q[1];
          rdata_d[`PMWC_MISC_SEL_LO] = sel_q[0];
        end
        `PMWC_OFS_CRSS: begin
          rdata_d[`PMWC_CRSS_IE]   = css_ie_q;
          rdata_d[`PMWC_CRSS_FLAG] = css_flag_q;
        end
        `PMWC_OFS_STAT: begin
          rdata_d[3:0] = st_q;
          rdata_d[4]   = i_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
    if (acc_wr && avs_address == `PMWC_OFS_MISC) begin
      slow_en_d = avs_writedata[`PMWC_MISC_SMS];
      sel_d     = {avs_writedata[`PMWC_MISC_SEL_HI],
                   avs_writedata[`PMWC_MISC_SEL_LO]};
    end
    if (acc_wr && avs_address == `PMWC_OFS_CRSS) begin
      css_ie_d = avs_writedata[`PMWC_CRSS_IE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      slow_en_q       <= `PMWC_RST_SMS;
      sel_q           <= `PMWC_RST_SEL;
      css_ie_q        <= `PMWC_RST_IE;
      css_flag_q      <= 1'b0;
    end else begin
      avs_waitrequest <= wreq_d;
      avs_readdata    <= rdata_d;
      slow_en_q       <= slow_en_d;
      sel_q           <= sel_d;
      css_ie_q        <= css_ie_d;
      css_flag_q      <= css_flag_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_halt_enter;
    st_q == PMWC_S_RUN ##1 st_q == PMWC_S_HALT;
  endsequence

  sequence s_start_done;
    st_q == PMWC_S_START ##1 st_q == PMWC_S_RUN;
  endsequence

  property p_halt_mask;
    s_halt_enter |-> !i_mask && !osc_enable;
  endproperty
  a_halt_mask: assert property (p_halt_mask)
    else $error("halt entry left mask or oscillator on");

  property p_wait_mask;
    $rose(st_q == PMWC_S_WAIT) |-> !i_mask ##0 !cpu_clk_en;
  endproperty
  a_wait_mask: assert property (p_wait_mask)
    else $error("wait entry did not clear mask");

  property p_ack_push;
    ack |=> i_mask && cc_push ##1 !cc_push;
  endproperty
  a_ack_push: assert property (p_ack_push)
    else $error("service entry did not push cc and mask");

  property p_trap;
    trap_instr && st_q == PMWC_S_RUN && st_d == PMWC_S_RUN
      && !vec_ack |-> ##[1:2]
      (irq_req && irq_vector == `PMWC_VEC_TRAP);
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap not requested");

  property p_start_len;
    s_start_done |-> $past(st_cnt_q) == `PMWC_STARTUP_LAST;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("halt exit delay wrong length");

  property p_halt_hold;
    st_q == PMWC_S_HALT && !halt_wake |=> st_q == PMWC_S_HALT;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt left without wake source");

  property p_run_div;
    periph_clk_en && ratio_q == `PMWC_DIV_RUN
      && st_q == PMWC_S_RUN |=> !periph_clk_en;
  endproperty
  a_run_div: assert property (p_run_div)
    else $error("run tick spacing wrong");

  property p_wdg;
    halt_instr && st_q == PMWC_S_RUN && watchdog_en
      && !watchdog_in_halt_option
      |=> wdg_reset_req && st_q == PMWC_S_RUN;
  endproperty
  a_wdg: assert property (p_wdg)
    else $error("watchdog halt option ignored");

  property p_bus;
    (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer timing wrong");

endmodule

/* pmwc_top_tb.sv */
// self-checking bench for the power mode and wake controller
`timescale 1ns/1ps
`include "pmwc_defines.svh"

module pmwc_top_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        wait_for_interrupt_instr = 1'b0;
  logic        halt_instr = 1'b0;
  logic        trap_instr = 1'b0;
  logic        iret_pop;
  logic        vec_ack;
  logic        irq_req;
  logic [15:0] irq_vector;
  logic        i_mask;
  logic        cc_push;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        osc_enable;
  logic        wdg_reset_req;
  logic        watchdog_en = 1'b0;
  logic        watchdog_in_halt_option = 1'b0;
  logic        hold_ret = 1'b0;
  logic        ack_stb;
  logic [15:0] ack_vec;
  logic [6:0]  src = 7'h00;
  logic [6:0]  set;
  logic [31:0] rdat;
  logic [15:0] v;
  int          bad_count = 0;
  int          n_compared = 0;
  int          p, a, b, c, i, r;
  logic [15:0] vt [0:6] = '{`PMWC_VEC_EXTA, `PMWC_VEC_EXTB, `PMWC_VEC_CSS,
                            `PMWC_VEC_SPI, `PMWC_VEC_TIM1, `PMWC_VEC_TIM2,
                            `PMWC_VEC_I2C};

  pmwc_top i_pmwc_top (
    .ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest,
    .wait_for_interrupt_instr, .halt_instr, .trap_instr, .iret_pop,
    .vec_ack, .irq_req, .irq_vector, .i_mask, .cc_push, .cpu_clk_en,
    .periph_clk_en, .osc_enable, .wdg_reset_req,
    .ext_irq_group_a(src[0]), .ext_irq_group_b(src[1]),
    .clock_supervision(src[2]), .spi_irq(src[3]),
    .timer_one_status(src[4]), .timer_two_status(src[5]),
    .i2c_irq(src[6]), .watchdog_en, .watchdog_in_halt_option
  );

  pmwc_cpu_model i_pmwc_cpu_model (
    .ref_clk, .reset_n, .irq_req, .irq_vector, .cc_push, .hold_ret,
    .vec_ack, .iret_pop, .ack_stb, .ack_vec
  );

  always #10 ref_clk = ~ref_clk;

  // ****************************************
  // helpers
  // ****************************************
  task results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one avalon access; request stands until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    avs_address   <= ad;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 40);
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 40) chk("bus answer", 0, 1);
  endtask

  task pulse(input int k);
    @(posedge ref_clk);
    if (k == 0) trap_instr <= 1'b1;
    else if (k == 1) wait_for_interrupt_instr <= 1'b1;
    else halt_instr <= 1'b1;
    @(posedge ref_clk);
    trap_instr <= 1'b0;
    wait_for_interrupt_instr <= 1'b0;
    halt_instr <= 1'b0;
  endtask

  // spacing of enable pulses; 0 when uneven or missing
  task per(input bit pe, output int q);
    int n, last, k;
    n = 0;
    last = 0;
    k = 0;
    q = 0;
    while (k < 4 && n < 600) begin
      @(posedge ref_clk);
      n++;
      if ((pe ? periph_clk_en : cpu_clk_en) === 1'b1) begin
        if (k == 1) q = n - last;
        else if (k > 1 && n - last != q) q = 0;
        last = n;
        k++;
      end
    end
    if (k < 4) q = 0;
  endtask

  task cnt(input int n, output int ca, output int cb);
    ca = 0;
    cb = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (cpu_clk_en === 1'b1) ca++;
      if (periph_clk_en === 1'b1) cb++;
    end
  endtask

  task wait_ack(output logic [15:0] av);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_stb !== 1'b1 && n < 10000);
    av = ack_vec;
    if (n >= 10000) chk("ack wait", 0, 1);
  endtask

  function automatic int top(input logic [6:0] s);
    for (int j = 0; j < 7; j++) if (s[j]) return j;
    return 7;
  endfunction

  // ****************************************
  // watchdog on the run
  // ****************************************
  initial begin
    #1_000_000;
    bad_count++;
    results;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h6fe39f1d));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk("irq_req rst", irq_req, 0);
    chk("i_mask rst", i_mask, 1);
    per(0, p);
    chk("run period", p, 2);
    bus(0, `PMWC_OFS_MISC, 0);
    chk("misc rst", rdat, 0);
    bus(1, `PMWC_OFS_CRSS, 32'h0000_0004);
    bus(0, `PMWC_OFS_CRSS, 0);
    chk("css enable", rdat, 32'h0000_0004);
    bus(1, `PMWC_OFS_STAT, 32'h0000_001f);
    bus(0, `PMWC_OFS_STAT, 0);
    chk("status ro", rdat, 32'h0000_0011);
    bus(1, 4'hc, 32'hffff_ffff);
    bus(0, 4'hc, 0);
    chk("unmapped", rdat, 0);
    for (i = 0; i < 4; i++) begin
      bus(1, `PMWC_OFS_MISC, 32'h0000_0004 | i);
      cyc(80);
      per(0, p);
      chk("cpu slow div", p, 4 << i);
      per(1, p);
      chk("periph slow div", p, 4 << i);
    end
    bus(1, `PMWC_OFS_MISC, 0);
    cyc(80);
    per(1, p);
    chk("back to run", p, 2);
    // sources raised while masked, served in fixed order after return
    for (r = 0; r < 6; r++) begin
      pulse(0);
      wait_ack(v);
      chk("trap vector", v, `PMWC_VEC_TRAP);
      set = (r == 0) ? 7'h7f : 7'($urandom_range(1, 127));
      src <= set;
      while (set != 7'h00) begin
        wait_ack(v);
        i = top(set);
        chk("vector", v, vt[i]);
        src[i] <= 1'b0;
        set[i] = 1'b0;
        if (i == 2) begin
          bus(0, `PMWC_OFS_CRSS, 0);
          chk("css flag", rdat[1], 1);
        end
      end
    end
    bus(1, `PMWC_OFS_MISC, 32'h0000_0005);
    cyc(40);
    pulse(0);
    wait_ack(v);
    hold_ret <= 1'b1;
    pulse(1);
    cyc(2);
    bus(0, `PMWC_OFS_STAT, 0);
    chk("wait status", rdat, 32'h0000_0002);
    cnt(64, a, b);
    chk("wait cpu clk", a, 0);
    chk("slow wait periph", b, 8);
    src[5] <= 1'b1;
    wait_ack(v);
    chk("wait wake", v, `PMWC_VEC_TIM2);
    src[5] <= 1'b0;
    hold_ret <= 1'b0;
    bus(1, `PMWC_OFS_MISC, 0);
    cyc(80);
    watchdog_en <= 1'b1;
    watchdog_in_halt_option <= 1'b1;
    pulse(2);
    cyc(3);
    chk("halt osc", osc_enable, 0);
    src[5] <= 1'b1;
    cnt(50, a, b);
    chk("halt clocks", a + b, 0);
    chk("timer two stays", osc_enable, 0);
    src[5] <= 1'b0;
    cyc(4);
    src[1] <= 1'b1;
    c = 0;
    while (osc_enable !== 1'b1 && c < 20) begin
      @(posedge ref_clk);
      c++;
    end
    chk("osc restart", c <= 8, 1);
    c = 0;
    while (cpu_clk_en !== 1'b1 && c < 9000) begin
      @(posedge ref_clk);
      c++;
    end
    chk("startup span", c >= 8190 && c <= 8200, 1);
    wait_ack(v);
    chk("halt wake", v, `PMWC_VEC_EXTB);
    src[1] <= 1'b0;
    cyc(20);
    pulse(0);
    wait_ack(v);
    hold_ret <= 1'b1;
    src[0] <= 1'b1;
    cyc(8);
    pulse(2);
    cyc(3);
    bus(0, `PMWC_OFS_STAT, 0);
    chk("pending wakes", rdat, 32'h0000_0008);
    wait_ack(v);
    chk("ext a wake", v, `PMWC_VEC_EXTA);
    src[0] <= 1'b0;
    hold_ret <= 1'b0;
    cyc(20);
    watchdog_in_halt_option <= 1'b0;
    pulse(2);
    a = 0;
    repeat (4) begin
      @(posedge ref_clk);
      if (wdg_reset_req === 1'b1) a++;
    end
    chk("watchdog pulse", a, 1);
    chk("no halt", osc_enable, 1);
    results;
  end
endmodule
